/* File: verilog/laser_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LASER_CONSTS_SVH
`define LASER_CONSTS_SVH

// controller register byte offsets
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_INT_STAT 8'h08
`define REG_INT_MASK 8'h0C

// control register fields
`define CTRL_ESTOP1 0
`define CTRL_ESTOP2 1
`define CTRL_ILOCK 2
`define CTRL_TRESET 3
`define CTRL_TAKEOVER 4
`define CTRL_DIODE_EN 5
`define CTRL_BEAM1 6
`define CTRL_BEAM2 7
`define CTRL_RESET 8'h07

// status register fields
`define STAT_ESTOP1 0
`define STAT_ESTOP2 1
`define STAT_EXT_OK 2
`define STAT_DIODE_ON 3
`define STAT_SHUT1 4
`define STAT_SHUT2 5

// interrupt event fields
`define EV_ESTOP 0
`define EV_DIODE_ON 1
`define EV_EXT_OK 2
`define EV_SHUT_CLOSE 3
`define EV_RESET 4'h0

// timing
`define CLK_HZ 10000000
`define DIODE_ON_MAX_S 5
`define DIODE_ON_CYC (`DIODE_ON_MAX_S * `CLK_HZ)

`endif

/* File: verilog/laser_pkg.sv */
// types and shared decode for the laser safety interlock
package laser_pkg;

  // diode supply sequence
  typedef enum logic [1:0] {
    DIODE_OFF = 2'b00,
    DIODE_RAMP = 2'b01,
    DIODE_ON = 2'b10
  } diode_state_t;

  // true when every used pair was seen open and is now closed
  function automatic logic rearm_ok(input logic [3:0] seen_open,
                                    input logic [3:0] closed,
                                    input logic [3:0] used);
    rearm_ok = (&(seen_open | ~used)) & (&(closed | ~used));
  endfunction : rearm_ok

endpackage : laser_pkg

/* File: verilog/laser_link_if.sv */
// contact-level link between the laser unit and its safety controller
`timescale 1ns/10ps
interface laser_link_if;
  // controller to unit, 1 = contact closed
  logic [3:0] estop_pair_closed; // pairs 0,1 channel one; 2,3 channel two
  logic [1:0] ilock_pair_closed; // external interlock pairs
  logic trouble_reset; // reset request contact
  logic takeover; // external control takeover
  logic diode_enable; // diode supply request
  logic [1:0] beam_select; // beam one, beam two
  // unit to controller, 1 = contact closed
  logic [1:0] estop_status_closed; // dual stop status contacts
  logic ext_input_ok; // external input acceptable
  logic diode_on; // diode on status
  logic [1:0] shutter_open; // shutter open contacts

  modport unit (
    input estop_pair_closed, ilock_pair_closed, trouble_reset, takeover,
    input diode_enable, beam_select,
    output estop_status_closed, ext_input_ok, diode_on, shutter_open
  );

  modport controller (
    output estop_pair_closed, ilock_pair_closed, trouble_reset, takeover,
    output diode_enable, beam_select,
    input estop_status_closed, ext_input_ok, diode_on, shutter_open
  );
endinterface : laser_link_if

/* File: verilog/contact_sync.sv */
// two-stage synchroniser for a vector of contact levels
`timescale 1ns/10ps
module contact_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] raw_in,
  input wire logic [WIDTH-1:0] rst_val_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
  logic [WIDTH-1:0] hold_q; // second stage, stored relative to reset value

  // both stages reset to zero; levels are kept folded with the reset value
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      hold_q <= '0;
    end
    else
    begin
      meta_q <= raw_in ^ rst_val_in;
      hold_q <= meta_q;
    end
  end

  // unfold: reset shows rst_val_in, running shows the true level
  assign sync_out = hold_q ^ rst_val_in;
endmodule : contact_sync

/* File: verilog/laser_unit_end.sv */
// laser unit safety logic: stop latch, interlock latch, diode and shutters
//
// Design decisions made in the controller end and the constants header: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "laser_consts.svh"

// Functional notes
// - channel one pair open latches stop
// - channel two pair open latches stop
// - stop clears after all pairs cycled, reset
// - interlock pair one open closes shutter
// - interlock pair two open closes shutter
// - interlock clears after both cycled, reset
// - stop opens status contact one
// - stop opens status contact two
// - controller moves both channel pairs together
// - controller safety relay clears the stop
// - takeover gives external-input-acceptable status
// - diode enable: power, status within five seconds
// - diode status waits for warm module
// - beam select opens shutter, lights lamp
// - no-shutter variant: beam one always selected
module laser_unit_end
  import laser_pkg::*;
#(
  parameter int unsigned DIODE_DELAY_CYC = `DIODE_ON_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  laser_link_if.unit link,
  input wire logic module_warm_in,
  input wire logic no_shutter_in,
  output logic laser_diode_source_out,
  output logic [1:0] shutter_drive_out,
  output logic [1:0] shutter_lamp_out,
  output logic estop_active_out,
  output logic ilock_active_out
);
  // synchronised link inputs, 1 = closed
  logic [3:0] estop_closed; // four stop pairs
  logic [1:0] ilock_closed; // two interlock pairs
  logic [5:0] misc_sync; // reset, takeover, diode, beams, warm
  logic strap_sync; // no-shutter strap
  logic treset; // trouble reset level
  logic takeover; // control takeover level
  logic diode_req; // diode enable level
  logic [1:0] beam_req; // beam select levels
  logic warm; // module at temperature

  // stop and interlock state
  logic estop_q; // latched emergency stop
  logic ilock_q; // latched interlock
  logic [3:0] estop_seen_q; // stop pairs seen open since latch
  logic [1:0] ilock_seen_q; // interlock pairs seen open since latch
  logic treset_q; // previous trouble reset level
  logic treset_rise; // trouble reset edge
  logic variant_q; // captured no-shutter strap

  // diode sequence
  diode_state_t diode_st_q; // supply state
  diode_state_t diode_st_d; // next supply state
  logic [25:0] ramp_cnt_q; // power-up delay counter
  logic ramp_done; // delay elapsed

  // beam selection after variant override
  logic [1:0] beam_eff;

  // stop pairs synchronised; reset value closed so nothing latches falsely
  contact_sync #(
    .WIDTH(4)
  ) u_sync_estop (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(link.estop_pair_closed),
    .rst_val_in(4'hF),
    .sync_out(estop_closed)
  );

  // interlock pairs synchronised the same way
  contact_sync #(
    .WIDTH(2)
  ) u_sync_ilock (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(link.ilock_pair_closed),
    .rst_val_in(2'h3),
    .sync_out(ilock_closed)
  );

  // remaining levels, including the warm-up sensor
  contact_sync #(
    .WIDTH(6)
  ) u_sync_misc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in({module_warm_in, link.beam_select, link.diode_enable,
             link.takeover, link.trouble_reset}),
    .rst_val_in(6'h00),
    .sync_out(misc_sync)
  );

  // variant strap, synchronised and registered every cycle, so variant_q follows the strap
  contact_sync #(
    .WIDTH(1)
  ) u_sync_strap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(no_shutter_in),
    .rst_val_in(1'h0),
    .sync_out(strap_sync)
  );

  // unpack synchronised levels
  assign treset = misc_sync[0];
  assign takeover = misc_sync[1];
  assign diode_req = misc_sync[2];
  assign beam_req = misc_sync[4:3];
  assign warm = misc_sync[5];
  assign treset_rise = treset & ~treset_q;

  // trouble reset edge detector and strap capture
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      treset_q <= 1'b0;
      variant_q <= 1'b0;
    end
    else
    begin
      treset_q <= treset;
      variant_q <= strap_sync;
    end
  end

  // emergency stop latch with per-pair re-arm tracking
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      estop_q <= 1'b0;
      estop_seen_q <= 4'h0;
    end
    else if (!(&estop_closed))
    begin
      estop_q <= 1'b1;
      estop_seen_q <= estop_seen_q | ~estop_closed;
    end
    else if (estop_q && treset_rise &&
             rearm_ok(estop_seen_q, estop_closed, 4'hF))
    begin
      estop_q <= 1'b0;
      estop_seen_q <= 4'h0;
    end
  end

  // interlock latch with per-pair re-arm tracking
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ilock_q <= 1'b0;
      ilock_seen_q <= 2'h0;
    end
    else if (!(&ilock_closed))
    begin
      ilock_q <= 1'b1;
      ilock_seen_q <= ilock_seen_q | ~ilock_closed;
    end
    else if (ilock_q && treset_rise &&
             rearm_ok({2'h3, ilock_seen_q}, {2'h3, ilock_closed}, 4'h3))
    begin
      ilock_q <= 1'b0;
      ilock_seen_q <= 2'h0;
    end
  end

  // diode next state
  always_comb
  begin
    diode_st_d = diode_st_q;
    unique case (diode_st_q)
      DIODE_OFF:
      begin
        // power only under external control and no stop
        if (takeover && diode_req && !estop_q && !(&estop_closed) == 1'b0)
          diode_st_d = DIODE_RAMP;
      end
      DIODE_RAMP:
      begin
        if (!diode_req || !takeover || estop_q)
          diode_st_d = DIODE_OFF;
        else if (ramp_done && warm)
          diode_st_d = DIODE_ON;
      end
      DIODE_ON:
      begin
        // any stop or withdrawn request drops supply
        if (!diode_req || !takeover || estop_q)
          diode_st_d = DIODE_OFF;
      end
      default:
      begin
        diode_st_d = DIODE_OFF;
      end
    endcase
  end

  assign ramp_done = (ramp_cnt_q >= 26'(DIODE_DELAY_CYC - 1));

  // diode state and power-up counter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      diode_st_q <= DIODE_OFF;
      ramp_cnt_q <= 26'h0000000;
    end
    else
    begin
      diode_st_q <= diode_st_d;
      // counter runs only while ramping, saturates
      if (diode_st_q != DIODE_RAMP)
        ramp_cnt_q <= 26'h0000000;
      else if (!ramp_done)
        ramp_cnt_q <= ramp_cnt_q + 26'h0000001;
    end
  end

  assign beam_eff = {beam_req[1], beam_req[0] | variant_q};

  // outputs towards the laser hardware and the link
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      laser_diode_source_out <= 1'b0;
      shutter_drive_out <= 2'h0;
      shutter_lamp_out <= 2'h0;
      estop_active_out <= 1'b0;
      ilock_active_out <= 1'b0;
      link.estop_status_closed <= 2'h3;
      link.ext_input_ok <= 1'b0;
      link.diode_on <= 1'b0;
      link.shutter_open <= 2'h0;
    end
    else
    begin
      laser_diode_source_out <= (diode_st_d != DIODE_OFF) && !estop_q &&
                                (&estop_closed);
      shutter_drive_out <= (takeover && !estop_q && !ilock_q &&
                            (&estop_closed) && (&ilock_closed)) ? beam_eff : 2'h0;
      shutter_lamp_out <= (takeover && !estop_q && !ilock_q &&
                           (&estop_closed) && (&ilock_closed)) ? beam_eff : 2'h0;
      link.shutter_open <= (takeover && !estop_q && !ilock_q &&
                            (&estop_closed) && (&ilock_closed)) ? beam_eff : 2'h0;
      estop_active_out <= estop_q;
      ilock_active_out <= ilock_q;
      link.estop_status_closed <= {2{!estop_q && (&estop_closed)}};
      link.ext_input_ok <= takeover;
      link.diode_on <= (diode_st_d == DIODE_ON);
    end
  end
endmodule : laser_unit_end

/* File: verilog/safety_ctrl_end.sv */
// safety controller end: APB registers driving the laser contacts
`timescale 1ns/10ps
`include "laser_consts.svh"
module safety_ctrl_end
  import laser_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  laser_link_if.controller link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out
);
  logic [7:0] ctrl_q; // contact command register
  logic [5:0] stat; // synchronised unit status
  logic [5:0] stat_q; // previous status for edges
  logic [3:0] int_stat_q; // sticky events
  logic [3:0] int_mask_q; // event enables
  logic [3:0] events; // this cycle's events
  logic wr_en; // write accepted this edge
  logic mapped; // address decodes

  // unit status synchronised; stop contacts idle closed
  contact_sync #(
    .WIDTH(6)
  ) u_sync_stat (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in({link.shutter_open, link.diode_on, link.ext_input_ok,
             link.estop_status_closed}),
    .rst_val_in(6'h03),
    .sync_out(stat)
  );

  assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STAT) ||
                  (paddr == `REG_INT_STAT) || (paddr == `REG_INT_MASK);
  assign wr_en = psel && penable && pready && pwrite && mapped;

  // edge events from the unit
  assign events[`EV_ESTOP] = stat_q[`STAT_ESTOP1] & ~stat[`STAT_ESTOP1];
  assign events[`EV_DIODE_ON] = ~stat_q[`STAT_DIODE_ON] & stat[`STAT_DIODE_ON];
  assign events[`EV_EXT_OK] = ~stat_q[`STAT_EXT_OK] & stat[`STAT_EXT_OK];
  assign events[`EV_SHUT_CLOSE] = |(stat_q[5:4] & ~stat[5:4]);

  // bus answer: ready one cycle after setup
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      unique case (paddr)
        `REG_CTRL: prdata <= {24'h000000, ctrl_q};
        `REG_STAT: prdata <= {26'h0000000, stat};
        `REG_INT_STAT: prdata <= {28'h0000000, int_stat_q};
        `REG_INT_MASK: prdata <= {28'h0000000, int_mask_q};
        default: prdata <= 32'h00000000;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // command and mask registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= `CTRL_RESET;
      int_mask_q <= 4'h0;
    end
    else if (wr_en && paddr == `REG_CTRL)
      ctrl_q <= pwdata[7:0];
    else if (wr_en && paddr == `REG_INT_MASK)
      int_mask_q <= pwdata[3:0];
  end

  // sticky events, set wins over write-one-clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      int_stat_q <= `EV_RESET;
      stat_q <= 6'h03;
    end
    else
    begin
      stat_q <= stat;
      if (wr_en && paddr == `REG_INT_STAT)
        int_stat_q <= (int_stat_q & ~pwdata[3:0]) | events;
      else
        int_stat_q <= int_stat_q | events;
    end
  end

  // contact outputs and interrupt level
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      link.estop_pair_closed <= 4'hF;
      link.ilock_pair_closed <= 2'h3;
      link.trouble_reset <= 1'b0;
      link.takeover <= 1'b0;
      link.diode_enable <= 1'b0;
      link.beam_select <= 2'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      // pairs of a channel move together
      link.estop_pair_closed <= {{2{ctrl_q[`CTRL_ESTOP2]}}, {2{ctrl_q[`CTRL_ESTOP1]}}};
      link.ilock_pair_closed <= {2{ctrl_q[`CTRL_ILOCK]}};
      link.trouble_reset <= ctrl_q[`CTRL_TRESET];
      link.takeover <= ctrl_q[`CTRL_TAKEOVER];
      link.diode_enable <= ctrl_q[`CTRL_DIODE_EN];
      link.beam_select <= {ctrl_q[`CTRL_BEAM2], ctrl_q[`CTRL_BEAM1]};
      irq_out <= |((int_stat_q | events) & int_mask_q);
    end
  end
endmodule : safety_ctrl_end

/* File: sim/laser_link_properties.sv */
// concurrent checks on the contact link between the two ends
`timescale 1ns/10ps
module laser_link_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] estop_pair_closed,
  input wire logic [1:0] ilock_pair_closed,
  input wire logic trouble_reset,
  input wire logic takeover,
  input wire logic diode_enable,
  input wire logic [1:0] beam_select,
  input wire logic [1:0] estop_status_closed,
  input wire logic ext_input_ok,
  input wire logic diode_on,
  input wire logic [1:0] shutter_open
);
  logic tr_prev_q; // reset request last cycle
  logic [3:0] tr_age_q; // cycles since reset request rose
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // age of the last reset request edge, saturating
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tr_prev_q <= 1'b0;
      tr_age_q <= 4'hF;
    end
    else
    begin
      tr_prev_q <= trouble_reset;
      if (trouble_reset && !tr_prev_q)
        tr_age_q <= 4'h0;
      else if (tr_age_q != 4'hF)
        tr_age_q <= tr_age_q + 4'h1;
    end
  end
  // channel pair open, and the safe state it forces
  sequence s_ch_one_open;
    !(&estop_pair_closed[1:0]);
  endsequence
  sequence s_ch_two_open;
    !(&estop_pair_closed[3:2]);
  endsequence
  sequence s_all_safe;
    estop_status_closed == 2'b00 && !diode_on && shutter_open == 2'b00;
  endsequence
  sequence s_status_back;
    $rose(estop_status_closed[0]);
  endsequence
  a_ch_one_stop: assert property (s_ch_one_open |-> ##4 s_all_safe)
    else $error("channel one open did not stop");
  a_ch_two_stop: assert property (s_ch_two_open |-> ##4 s_all_safe)
    else $error("channel two open did not stop");
  a_ilock_one_shut: assert property (!ilock_pair_closed[0] |-> ##4 shutter_open == 2'b00)
    else $error("interlock one open left a shutter open");
  a_ilock_two_shut: assert property (!ilock_pair_closed[1] |-> ##4 shutter_open == 2'b00)
    else $error("interlock two open left a shutter open");
  a_status_pair_agree: assert property (estop_status_closed[0] == estop_status_closed[1])
    else $error("stop status contacts disagree");
  a_pairs_move_together: assert property (estop_pair_closed[0] == estop_pair_closed[1] &&
    estop_pair_closed[2] == estop_pair_closed[3] && ilock_pair_closed[0] == ilock_pair_closed[1])
    else $error("channel pairs moved apart");
  a_takeover_ext_ok: assert property ($rose(takeover) |-> ##[2:4] ext_input_ok)
    else $error("takeover not acknowledged");
  a_diode_has_cause: assert property ($rose(diode_on) |-> $past(diode_enable, 3) && $past(takeover, 3))
    else $error("diode status without request");
  a_beam_two_cause: assert property (shutter_open[1] |-> $past(beam_select[1], 2) ||
    $past(beam_select[1], 3) || $past(beam_select[1], 4))
    else $error("shutter two open without select");
  a_clear_needs_reset: assert property (s_status_back |-> tr_age_q <= 4'h6 && (&estop_pair_closed))
    else $error("stop cleared without reset request");
endmodule : laser_link_properties

/* File: sim/tb_laser_safety_interlock_control.sv */
// self-checking bench joining the controller end and the unit end
`timescale 1ns/10ps
`include "laser_consts.svh"
module tb_laser_safety_interlock_control;
  localparam logic [31:0] RUN = 32'h000000B0; // takeover, diode request, beam two
  logic clk_in = 1'b0; // free-running bench clock
  logic rst_in, psel, penable, pwrite, pready, pslverr, irq_out;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic module_warm_in, no_shutter_in, diode_src, estop_act, ilock_act;
  logic [1:0] shut_drv, shut_lamp;
  int err_total, comparisons, cyc;
  laser_link_if link();
  laser_unit_end #(.DIODE_DELAY_CYC(20)) laser_unit_end_inst (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.unit), .module_warm_in(module_warm_in), .no_shutter_in(no_shutter_in),
    .laser_diode_source_out(diode_src), .shutter_drive_out(shut_drv),
    .shutter_lamp_out(shut_lamp), .estop_active_out(estop_act), .ilock_active_out(ilock_act));
  safety_ctrl_end safety_ctrl_end_inst (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.controller), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out));
  laser_link_properties laser_link_properties_inst (.clk_in(clk_in), .rst_in(rst_in),
    .estop_pair_closed(link.estop_pair_closed), .ilock_pair_closed(link.ilock_pair_closed),
    .trouble_reset(link.trouble_reset), .takeover(link.takeover),
    .diode_enable(link.diode_enable), .beam_select(link.beam_select),
    .estop_status_closed(link.estop_status_closed), .ext_input_ok(link.ext_input_ok),
    .diode_on(link.diode_on), .shutter_open(link.shutter_open));
  // clock and hang guard
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check(32'(e), 32'h00000000);
  endtask : rd_chk
  // reset values, mask, unmapped place
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk(`REG_CTRL, 32'h00000007);
    rd_chk(`REG_STAT, 32'h00000003);
    rd_chk(`REG_INT_STAT, 32'h00000000);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, r, e);
    check(32'(e), 32'h00000001);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check(r, 32'h00000000);
    check(32'(e), 32'h00000001);
    wr(`REG_INT_MASK, 32'h0000000F);
    rd_chk(`REG_INT_MASK, 32'h0000000F);
    rd_chk(`REG_CTRL, 32'h00000007);
  endtask : t_regs
  // takeover, diode power-up while cold then warm, beam two, strap
  task automatic t_run_up();
    wr(`REG_CTRL, 32'h00000017);
    tick(6);
    rd_chk(`REG_STAT, 32'h00000007);
    rd_chk(`REG_INT_STAT, 32'h00000004);
    check(32'(irq_out), 32'h1);
    wr(`REG_INT_STAT, 32'h0000000F);
    tick(2);
    check(32'(irq_out), 32'h0);
    wr(`REG_CTRL, 32'h00000037);
    tick(40);
    check(32'(diode_src), 32'h1);
    rd_chk(`REG_STAT, 32'h00000007);
    module_warm_in <= 1'b1;
    tick(6);
    rd_chk(`REG_STAT, 32'h0000000F);
    wr(`REG_CTRL, RUN | 32'h7);
    tick(6);
    rd_chk(`REG_STAT, 32'h0000002F);
    check(32'(shut_lamp), 32'h2);
    no_shutter_in <= 1'b1;
    tick(6);
    check(32'(shut_drv), 32'h3);
    no_shutter_in <= 1'b0;
    tick(6);
    check(32'(shut_drv), 32'h2);
    wr(`REG_INT_STAT, 32'h0000000F);
  endtask : t_run_up
  // stop on one channel, refused resets, release after all four pairs
  task automatic t_stop(input int ch);
    logic [31:0] op, ot;
    op = RUN | (32'h7 & ~(32'h1 << ch));
    ot = RUN | (32'h7 & ~(32'h1 << (1 - ch)));
    wr(`REG_INT_MASK, (ch == 0) ? 32'hF : 32'h0);
    wr(`REG_CTRL, op);
    tick(6);
    check(32'({estop_act, diode_src, shut_drv}), 32'h8);
    rd_chk(`REG_STAT, 32'h00000004);
    rd_chk(`REG_INT_STAT, 32'h00000009);
    check(32'(irq_out), (ch == 0) ? 32'h1 : 32'h0);
    wr(`REG_CTRL, op | 32'h8);
    tick(6);
    check(32'(estop_act), 32'h1);
    wr(`REG_CTRL, RUN | 32'hF);
    wr(`REG_CTRL, RUN | 32'h7);
    wr(`REG_CTRL, RUN | 32'hF);
    tick(6);
    check(32'(estop_act), 32'h1);
    wr(`REG_CTRL, ot);
    wr(`REG_CTRL, RUN | 32'h7);
    wr(`REG_CTRL, RUN | 32'hF);
    tick(6);
    check(32'({estop_act, shut_drv}), 32'h2);
    tick(30);
    rd_chk(`REG_STAT, 32'h0000002F);
    wr(`REG_CTRL, RUN | 32'h7);
    wr(`REG_INT_STAT, 32'h0000000F);
  endtask : t_stop
  // interlock closes shutters only, release needs reset after reclose
  task automatic t_ilock();
    wr(`REG_CTRL, RUN | 32'h3);
    tick(6);
    check(32'({ilock_act, estop_act, diode_src, shut_drv}), 32'h14);
    wr(`REG_CTRL, RUN | 32'hB);
    tick(6);
    check(32'(ilock_act), 32'h1);
    wr(`REG_CTRL, RUN | 32'hF);
    tick(6);
    check(32'(ilock_act), 32'h1);
    wr(`REG_CTRL, RUN | 32'h7);
    wr(`REG_CTRL, RUN | 32'hF);
    tick(6);
    check(32'({ilock_act, shut_drv}), 32'h2);
    wr(`REG_CTRL, RUN | 32'h7);
  endtask : t_ilock
  // main sequence
  initial
  begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    module_warm_in = 1'b0;
    no_shutter_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_run_up();
    t_stop(0);
    t_stop(1);
    t_ilock();
    test_done();
  end
endmodule : tb_laser_safety_interlock_control
